// file: verilog/ilc_consts.vh
// Constants of the interrupt level controller: register indexes, field
// layout, reset values and event bits.
// Assumes it is included by bare name from each design file that needs it.
//
// Notes on behaviour
// - The controller takes twelve request lines, each with its own two-bit level field.
// - A field with high bit 0 gives level 1, pattern 10 gives level 2, pattern 11 gives level 3 meaning none.
// - Fields sit four per byte in registers at indexes 7C to 7E, request n in bits 2(n mod 4)+1 and 2(n mod 4) of byte n/4.
// - An asserted request presents to the CPU the level taken from its own field.
// - Several active requests give one winner by priority, ties included, and only its level goes out.
// - A request stays up until the service routine clears its source, which ends processing for it.
// - A test register at index 7F holds two bits, 1 and 0, that reset to zero and are not used in normal work.
`ifndef ILC_CONSTS_VH
`define ILC_CONSTS_VH

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define ILC_NUM_REQ     12
`define ILC_NUM_W       4
`define ILC_ADDR_W      12

// ----------------------------------------------------------------------
// Register indexes; byte address is four times the index
// ----------------------------------------------------------------------
`define ILC_IDX_LVL0    10'h07C
`define ILC_IDX_LVL1    10'h07D
`define ILC_IDX_LVL2    10'h07E
`define ILC_IDX_TEST    10'h07F
`define ILC_IDX_STS     10'h080
`define ILC_IDX_CLR     10'h081
`define ILC_IDX_ENA     10'h082
`define ILC_IDX_WIN     10'h083
`define ILC_IDX_REQ     10'h084

// ----------------------------------------------------------------------
// Reset values and field encodings
// ----------------------------------------------------------------------
`define ILC_LVL_RST     8'hFF
`define ILC_TEST_RST    2'h0
`define ILC_LVL_ONE     2'h1
`define ILC_LVL_TWO     2'h2
`define ILC_LVL_NONE    2'h3

// ----------------------------------------------------------------------
// Event bits of the status, clear and enable registers
// ----------------------------------------------------------------------
`define ILC_EVT_W       3
`define ILC_EVT_NEW     0
`define ILC_EVT_TIE     1
`define ILC_EVT_MASKED  2

`endif

// file: verilog/ilc_arbiter.v
// Combinational arbiter: decodes each level field and picks one winner.
// Assumes request lines and fields are stable in the ref_clk domain.
`timescale 1ns/100ps
`include "ilc_consts.vh"

module ilc_arbiter
#(
   parameter NREQ = 12
)
(
   input  wire [NREQ-1:0]     reqIn,     // Active request lines
   input  wire [2*NREQ-1:0]   lvlFields, // Packed two-bit level fields
   output reg                 winValid,  // Some request may be forwarded
   output reg  [1:0]          winLevel,  // Winner level, none when idle
   output reg  [3:0]          winNum,    // Winner request number
   output reg                 winTie,    // Others share the best level
   output reg                 maskedAny  // Active request set to none
);

   // Field decode, used by both passes below
   function [1:0] decode_level;
      input [1:0] fld;
      begin
         if (!fld[1])
            decode_level = `ILC_LVL_ONE;
         else if (!fld[0])
            decode_level = `ILC_LVL_TWO;
         else
            decode_level = `ILC_LVL_NONE;
      end
   endfunction

   integer i;
   reg [1:0] lvl;

   // Strict compare keeps the first, lowest numbered request on a tie
   always @*
   begin
      winValid  = 1'b0;
      winLevel  = `ILC_LVL_NONE;
      winNum    = 4'h0;
      winTie    = 1'b0;
      maskedAny = 1'b0;
      lvl       = `ILC_LVL_NONE;
      for (i = 0; i < NREQ; i = i + 1)
      begin
         lvl = decode_level(lvlFields[2*i +: 2]);
         if (reqIn[i] && lvl == `ILC_LVL_NONE)
            maskedAny = 1'b1;
         if (reqIn[i] && lvl < winLevel)
         begin
            winValid = 1'b1;
            winLevel = lvl;
            winNum   = i[3:0];
         end
      end
      for (i = 0; i < NREQ; i = i + 1)
      begin
         lvl = decode_level(lvlFields[2*i +: 2]);
         if (winValid && reqIn[i] && lvl == winLevel
             && i[3:0] != winNum)
            winTie = 1'b1;
      end
   end

endmodule // ilc_arbiter

// file: verilog/ilc_evt_status.v
// Sticky event status with clear and enable registers, one level irq.
// Assumes single clock domain and strobes that last one enabled cycle.
`timescale 1ns/100ps
`include "ilc_consts.vh"

module ilc_evt_status
#(
   parameter W = 3
)
(
   input  wire          ref_clk,  // System clock
   input  wire          rst,      // Asynchronous reset, active high
   input  wire          clkEn,    // Freezes all state while low
   input  wire [W-1:0]  evtSet,   // Event pulses or levels
   input  wire          clrWr,    // Write strobe of clear register
   input  wire          enaWr,    // Write strobe of enable register
   input  wire [W-1:0]  wrData,   // Write data for both strobes
   output wire [W-1:0]  sts,      // Sticky status
   output wire [W-1:0]  ena,      // Enable mask
   output wire          irq       // High while an enabled bit is set
);

   reg [W-1:0] sts_ff;
   reg [W-1:0] ena_ff;
   reg         irq_ff;
   wire [W-1:0] nxt_sts;
   wire [W-1:0] nxt_ena;

   // Set wins over a clear in the same cycle so no event is lost
   assign nxt_sts = (sts_ff & ~(clrWr ? wrData : {W{1'b0}})) | evtSet;
   assign nxt_ena = enaWr ? wrData : ena_ff;

   // Irq registered from next values so it follows status at once
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         sts_ff <= {W{1'b0}};
         ena_ff <= {W{1'b0}};
         irq_ff <= 1'b0;
      end
      else if (clkEn)
      begin
         sts_ff <= nxt_sts;
         ena_ff <= nxt_ena;
         irq_ff <= |(nxt_sts & nxt_ena);
      end
   end

   assign sts = sts_ff;
   assign ena = ena_ff;
   assign irq = irq_ff;

endmodule // ilc_evt_status

// file: verilog/ilc_controller.v
// Interrupt level controller top: APB register file, level fields,
// arbitration and the registered level presented to the CPU core.
// Assumes request lines come from logic on ref_clk, so no synchroniser,
// and an APB master that holds each request until pready is seen.
`timescale 1ns/100ps
`include "ilc_consts.vh"

module ilc_controller
#(
   parameter NREQ = `ILC_NUM_REQ
)
(
   input  wire                   ref_clk,     // System clock, 200 MHz
   input  wire                   rst,         // Async reset, active high
   input  wire                   clkEn,       // Freezes state while low
   // APB slave
   input  wire                   psel,        // Slave select
   input  wire                   penable,     // Access phase
   input  wire                   pwrite,      // Write when high
   input  wire [`ILC_ADDR_W-1:0] paddr,       // Byte address
   input  wire [31:0]            pwdata,      // Write data
   output wire [31:0]            prdata,      // Read data
   output wire                   pready,      // Transfer done
   output wire                   pslverr,     // Unmapped address
   // Peripherals
   input  wire [NREQ-1:0]        reqIn,       // Request lines
   // CPU core
   output wire [1:0]             cpuLevel,    // Requested level
   output wire                   cpuReqValid, // A level is presented
   output wire [`ILC_NUM_W-1:0]  cpuReqNum,   // Winning request number
   // System
   output wire                   irq,         // Event interrupt, level
   output wire [1:0]             testBits     // Test register bits
);

   // -------------------------------------------------------------------
   // Address decode
   // -------------------------------------------------------------------

   // Word index of a byte address; low two bits are the byte lane
   function [9:0] word_index;
      input [`ILC_ADDR_W-1:0] adr;
      begin
         word_index = adr[`ILC_ADDR_W-1:2];
      end
   endfunction

   // True when the index belongs to a register of this block
   function mapped_index;
      input [9:0] idx;
      begin
         case (idx)
            `ILC_IDX_LVL0,
            `ILC_IDX_LVL1,
            `ILC_IDX_LVL2,
            `ILC_IDX_TEST,
            `ILC_IDX_STS,
            `ILC_IDX_CLR,
            `ILC_IDX_ENA,
            `ILC_IDX_WIN,
            `ILC_IDX_REQ : mapped_index = 1'b1;
            default      : mapped_index = 1'b0;
         endcase
      end
   endfunction

   // -------------------------------------------------------------------
   // Storage
   // -------------------------------------------------------------------

   reg  [7:0]             lvlSel_ff [0:2];  // level_select_0_3 .. 8_11
   reg  [1:0]             testCtl_ff;       // factory_test_control
   reg  [31:0]            prdata_ff;
   reg                    pready_ff;
   reg                    pslverr_ff;
   reg  [1:0]             cpuLevel_ff;
   reg                    cpuValid_ff;
   reg  [`ILC_NUM_W-1:0]  cpuNum_ff;

   reg  [31:0]            nxt_prdata;
   reg                    nxt_pslverr;

   wire [9:0]             accIdx;
   wire                   setupPh;
   wire                   accessDone;
   wire                   wrDone;
   wire [2*NREQ-1:0]      lvlFields;

   wire                   winValid;
   wire [1:0]             winLevel;
   wire [3:0]             winNum;
   wire                   winTie;
   wire                   maskedAny;

   wire [`ILC_EVT_W-1:0]  evtSet;
   wire [`ILC_EVT_W-1:0]  evtSts;
   wire [`ILC_EVT_W-1:0]  evtEna;
   wire                   irqInt;
   wire                   winChange;

   // -------------------------------------------------------------------
   // APB phase decode
   // -------------------------------------------------------------------

   // A write lands only on the edge at which the master sees pready
   assign accIdx     = word_index(paddr);
   assign setupPh    = psel & ~penable;
   assign accessDone = psel & penable & pready_ff;
   assign wrDone     = accessDone & pwrite;

   // -------------------------------------------------------------------
   // Level fields packed into one vector for the arbiter
   // -------------------------------------------------------------------

   // Request n takes bits 2(n mod 4)+1:2(n mod 4) of byte n/4
   genvar g;
   generate
      for (g = 0; g < NREQ; g = g + 1)
      begin : gFld
         assign lvlFields[2*g +: 2] =
            lvlSel_ff[g/4][2*(g%4) +: 2];
      end
   endgenerate

   // -------------------------------------------------------------------
   // Level register writes
   // -------------------------------------------------------------------

   // Full byte written from the low lane; upper data bits are dropped
   integer k;
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         for (k = 0; k < 3; k = k + 1)
            lvlSel_ff[k] <= `ILC_LVL_RST;
         testCtl_ff <= `ILC_TEST_RST;
      end
      else if (clkEn && wrDone)
      begin
         case (accIdx)
            `ILC_IDX_LVL0 : lvlSel_ff[0] <= pwdata[7:0];
            `ILC_IDX_LVL1 : lvlSel_ff[1] <= pwdata[7:0];
            `ILC_IDX_LVL2 : lvlSel_ff[2] <= pwdata[7:0];
            `ILC_IDX_TEST : testCtl_ff  <= pwdata[1:0];
            default       : ;
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Read data mux, evaluated in the setup cycle
   // -------------------------------------------------------------------

   // Read data is captured one cycle early; status set in the access
   // cycle itself shows on the next read, a deliberate zero-wait trade
   always @*
   begin
      nxt_prdata  = 32'h0000_0000;
      nxt_pslverr = 1'b0;
      case (accIdx)
         `ILC_IDX_LVL0 : nxt_prdata[7:0] = lvlSel_ff[0];
         `ILC_IDX_LVL1 : nxt_prdata[7:0] = lvlSel_ff[1];
         `ILC_IDX_LVL2 : nxt_prdata[7:0] = lvlSel_ff[2];
         `ILC_IDX_TEST : nxt_prdata[1:0] = testCtl_ff;
         `ILC_IDX_STS  : nxt_prdata[`ILC_EVT_W-1:0] = evtSts;
         `ILC_IDX_ENA  : nxt_prdata[`ILC_EVT_W-1:0] = evtEna;
         `ILC_IDX_WIN  :
         begin
            nxt_prdata[1:0] = cpuLevel_ff;
            nxt_prdata[7:4] = cpuNum_ff;
            nxt_prdata[8]   = cpuValid_ff;
         end
         `ILC_IDX_REQ  : nxt_prdata[NREQ-1:0] = reqIn;
         default       : nxt_prdata = 32'h0000_0000;
      endcase
      if (!mapped_index(accIdx))
         nxt_pslverr = 1'b1;
   end

   // -------------------------------------------------------------------
   // APB answer flops
   // -------------------------------------------------------------------

   // Every transfer gets exactly one access cycle with pready high
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         prdata_ff  <= 32'h0000_0000;
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end
      else if (clkEn)
      begin
         if (setupPh)
         begin
            prdata_ff  <= pwrite ? 32'h0000_0000 : nxt_prdata;
            pready_ff  <= 1'b1;
            pslverr_ff <= nxt_pslverr;
         end
         else
         begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------
   // Arbitration
   // -------------------------------------------------------------------

   // Peripherals raise lines only when source and own enable are set
   ilc_arbiter
   #(
      .NREQ      (NREQ)
   )
   uArb
   (
      .reqIn     (reqIn),
      .lvlFields (lvlFields),
      .winValid  (winValid),
      .winLevel  (winLevel),
      .winNum    (winNum),
      .winTie    (winTie),
      .maskedAny (maskedAny)
   );

   // -------------------------------------------------------------------
   // Level presented to the CPU
   // -------------------------------------------------------------------

   // Registered each cycle; holds while the request line stays up and
   // drops the cycle after the source is cleared by the routine
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         cpuLevel_ff <= `ILC_LVL_NONE;
         cpuValid_ff <= 1'b0;
         cpuNum_ff   <= {`ILC_NUM_W{1'b0}};
      end
      else if (clkEn)
      begin
         cpuLevel_ff <= winLevel;
         cpuValid_ff <= winValid;
         cpuNum_ff   <= winNum;
      end
   end

   // -------------------------------------------------------------------
   // Events
   // -------------------------------------------------------------------

   // A new or changed winner is an event; so is a tie at such a change
   // and a request held back because its field reads none
   assign winChange = winValid &
                      (~cpuValid_ff | (winNum != cpuNum_ff));
   assign evtSet[`ILC_EVT_NEW]    = winChange;
   assign evtSet[`ILC_EVT_TIE]    = winChange & winTie;
   assign evtSet[`ILC_EVT_MASKED] = maskedAny;

   ilc_evt_status
   #(
      .W       (`ILC_EVT_W)
   )
   uEvt
   (
      .ref_clk (ref_clk),
      .rst     (rst),
      .clkEn   (clkEn),
      .evtSet  (evtSet),
      .clrWr   (wrDone & (accIdx == `ILC_IDX_CLR)),
      .enaWr   (wrDone & (accIdx == `ILC_IDX_ENA)),
      .wrData  (pwdata[`ILC_EVT_W-1:0]),
      .sts     (evtSts),
      .ena     (evtEna),
      .irq     (irqInt)
   );

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------

   // The CPU side compares and enables on its own; only flops go out
   assign prdata      = prdata_ff;
   assign pready      = pready_ff;
   assign pslverr     = pslverr_ff;
   assign cpuLevel    = cpuLevel_ff;
   assign cpuReqValid = cpuValid_ff;
   assign cpuReqNum   = cpuNum_ff;
   assign irq         = irqInt;
   assign testBits    = testCtl_ff;

endmodule // ilc_controller

// file: verification/ilc_controller_assertions.sv
// Port checker of the interrupt level controller: winner sanity,
// APB answer timing and test register writes.
// Assumes one ref_clk domain with rst as its asynchronous reset.
`timescale 1ns/100ps
`include "ilc_consts.vh"

module ilc_controller_assertions
#(
   parameter NREQ = 12
)
(
   input wire                   ref_clk,     // System clock
   input wire                   rst,         // Async reset
   input wire                   clkEn,       // Clock enable
   input wire                   psel,        // Slave select
   input wire                   penable,     // Access phase
   input wire                   pwrite,      // Write when high
   input wire [`ILC_ADDR_W-1:0] paddr,       // Byte address
   input wire [31:0]            pwdata,      // Write data
   input wire [31:0]            prdata,      // Read data
   input wire                   pready,      // Transfer done
   input wire                   pslverr,     // Unmapped address
   input wire [NREQ-1:0]        reqIn,       // Request lines
   input wire [1:0]             cpuLevel,    // Requested level
   input wire                   cpuReqValid, // Level presented
   input wire [`ILC_NUM_W-1:0]  cpuReqNum,   // Winner number
   input wire                   irq,         // Event interrupt
   input wire [1:0]             testBits     // Test bits
);
   reg  [1:0] twHist_ff; // Test writes one and two edges ago
   wire       testWr;    // Accepted write to the test register

   // The copy may lag the register by one edge, so keep two edges
   assign testWr = psel && penable && pwrite && pready &&
                   (paddr[11:2] == `ILC_IDX_TEST);
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         twHist_ff <= 2'h0;
      else
         twHist_ff <= {twHist_ff[0], testWr};
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_none_never_fwd: assert property (cpuReqValid |->
      cpuLevel != `ILC_LVL_NONE) else $error("none level forwarded");
   a_idle_shows_none: assert property (!cpuReqValid |->
      cpuLevel == `ILC_LVL_NONE && cpuReqNum == 4'h0)
      else $error("idle outputs wrong");
   a_no_req_drops: assert property ((reqIn == 0 && clkEn) |=>
      !cpuReqValid) else $error("valid without request");
   a_winner_active: assert property ((cpuReqValid && $past(clkEn)) |->
      ((($past(reqIn) >> cpuReqNum) & 1) != 0))
      else $error("winner not requesting");
   a_num_in_range: assert property (cpuReqValid |->
      cpuReqNum < NREQ) else $error("winner number out of range");
   a_ready_after_setup: assert property ((psel && !penable && clkEn)
      |=> pready) else $error("no answer after setup");
   a_ready_one_cycle: assert property ((pready && clkEn) |=> !pready)
      else $error("pready too long");
   a_err_zero_data: assert property (pslverr |-> pready &&
      prdata == 32'h0) else $error("error answer carries data");
   a_test_write_only: assert property ($changed(testBits) |->
      twHist_ff != 2'h0) else $error("test bits moved without write");

   c_level_one: cover property (cpuReqValid && cpuLevel == 2'h1);
   c_level_two: cover property (cpuReqValid && cpuLevel == 2'h2);
   c_slave_err: cover property (pslverr);
   c_irq_up: cover property (irq);
endmodule // ilc_controller_assertions

bind ilc_controller ilc_controller_assertions #(.NREQ(NREQ))
   ilc_controller_assertions_inst (.ref_clk(ref_clk), .rst(rst),
   .clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .reqIn(reqIn), .cpuLevel(cpuLevel),
   .cpuReqValid(cpuReqValid), .cpuReqNum(cpuReqNum), .irq(irq),
   .testBits(testBits));

// file: verification/ilc_far_side_model.sv
// Far side model: twelve peripheral sources and the CPU level logic.
// Assumes set and clear pulses from the bench on ref_clk.
`timescale 1ns/100ps

module ilc_far_side_model
(
   input  wire        ref_clk,     // System clock
   input  wire        rst,         // Async reset
   input  wire [11:0] srcSet,      // Raise source pulses
   input  wire [11:0] srcClr,      // Service routine clears
   input  wire [11:0] srcEna,      // Per resource enables
   input  wire        gie,         // Global interrupt enable
   input  wire [1:0]  cpuLevel,    // Level from controller
   input  wire        cpuReqValid, // Level presented
   output wire [11:0] reqIn,       // Request lines
   output wire [1:0]  curLvl       // Current priority field
);
   reg [11:0] src_ff;    // Pending sources
   reg [1:0]  curLvl_ff; // Level now in service, 3 when idle

   assign reqIn = src_ff & srcEna;
   assign curLvl = curLvl_ff;

   // Source stays until cleared; CPU takes only a strictly higher level
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         src_ff <= 12'h000;
         curLvl_ff <= 2'h3;
      end
      else
      begin
         src_ff <= (src_ff | srcSet) & ~srcClr;
         if (cpuReqValid && cpuLevel < curLvl_ff && gie)
            curLvl_ff <= cpuLevel;
      end
   end
endmodule // ilc_far_side_model

// file: verification/ilc_controller_tb_top.sv
// Bench of the interrupt level controller: APB master, one task per
// scenario, far side model for resources and CPU.
// Assumes design, model and checker are compiled before this file.
`timescale 1ns/100ps

module ilc_controller_tb_top;
   reg         ref_clk = 1'b0;
   reg         rst = 1'b1;
   reg         clkEn = 1'b1;
   reg         psel = 1'b0;
   reg         penable = 1'b0;
   reg         pwrite = 1'b0;
   reg  [11:0] paddr = 12'h000;
   reg  [31:0] pwdata = 32'h0;
   reg  [11:0] srcSet = 12'h000;
   reg  [11:0] srcClr = 12'h000;
   reg  [11:0] srcEna = 12'hFFF;
   reg         gie = 1'b0;
   wire [31:0] prdata;
   wire        pready;
   wire        pslverr;
   wire [11:0] reqIn;
   wire [1:0]  cpuLevel;
   wire        cpuReqValid;
   wire [3:0]  cpuReqNum;
   wire        irq;
   wire [1:0]  testBits;
   wire [1:0]  curLvl;
   integer     err_total = 0;
   integer     checked = 0;
   integer     i;
   reg  [31:0] rd;
   reg         er;
   reg  [23:0] v;

   always #2.5 ref_clk = ~ref_clk;

   ilc_controller #(.NREQ(12)) ilc_controller_inst (.ref_clk(ref_clk),
      .rst(rst), .clkEn(clkEn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .reqIn(reqIn),
      .cpuLevel(cpuLevel), .cpuReqValid(cpuReqValid),
      .cpuReqNum(cpuReqNum), .irq(irq), .testBits(testBits));
   ilc_far_side_model ilc_far_side_model_inst (.ref_clk(ref_clk),
      .rst(rst), .srcSet(srcSet), .srcClr(srcClr), .srcEna(srcEna),
      .gie(gie), .cpuLevel(cpuLevel), .cpuReqValid(cpuReqValid),
      .reqIn(reqIn), .curLvl(curLvl));

   task end_of_test;
   begin
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   end
   endtask

   task chk(input [8*8-1:0] nm, input [31:0] seen, input [31:0] exp);
   begin
      checked = checked + 1;
      if (seen !== exp)
      begin
         err_total = err_total + 1;
         $display("CHECK FAILED %0s exp %h seen %h", nm, exp, seen);
      end
   end
   endtask

   // One APB transfer; values are read as sampled at the pready edge
   task apb(input w, input [11:0] a, input [31:0] d);
      integer n;
   begin
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      @(posedge ref_clk);
      while (pready !== 1'b1 && n < 20)
      begin
         @(posedge ref_clk);
         n = n + 1;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20)
      begin
         err_total = err_total + 1;
         end_of_test;
      end
   end
   endtask

   task rdchk(input [11:0] a, input [31:0] exp);
   begin
      apb(1'b0, a, 32'h0);
      chk("regread", rd, exp);
   end
   endtask

   task settle;
   begin
      repeat (3) @(posedge ref_clk);
   end
   endtask

   // Pulse source set and clear lines, then let the level pass through
   task src(input [11:0] s, input [11:0] c);
   begin
      @(posedge ref_clk);
      srcSet <= s;
      srcClr <= c;
      @(posedge ref_clk);
      srcSet <= 12'h000;
      srcClr <= 12'h000;
      settle;
   end
   endtask

   task cpu(input vl, input [1:0] l, input [3:0] n);
   begin
      chk("valid", cpuReqValid, vl);
      chk("level", cpuLevel, l);
      chk("number", cpuReqNum, n);
   end
   endtask

   task setv(input [23:0] f);
   begin
      apb(1'b1, 12'h1F0, {24'h0, f[7:0]});
      apb(1'b1, 12'h1F4, {24'h0, f[15:8]});
      apb(1'b1, 12'h1F8, {24'h0, f[23:16]});
      settle;
   end
   endtask

   task t_reset;
   begin
      rdchk(12'h1F0, 32'hFF);
      rdchk(12'h1F4, 32'hFF);
      rdchk(12'h1F8, 32'hFF);
      rdchk(12'h1FC, 32'h0);
      cpu(1'b0, 2'h3, 4'h0);
      $display("test reset done");
   end
   endtask

   // Request 5 walks through every field code; CPU takes only higher
   task t_decode;
   begin
      setv(24'hFFFBFF);
      src(12'h020, 12'h000);
      cpu(1'b1, 2'h2, 4'h5);
      chk("cur", curLvl, 2'h3);
      gie <= 1'b1;
      settle;
      chk("cur", curLvl, 2'h2);
      setv(24'hFFFFFF);
      cpu(1'b0, 2'h3, 4'h0);
      setv(24'hFFFBFF);
      chk("cur", curLvl, 2'h2);
      setv(24'hFFF3FF);
      cpu(1'b1, 2'h1, 4'h5);
      chk("cur", curLvl, 2'h1);
      setv(24'hFFF7FF);
      cpu(1'b1, 2'h1, 4'h5);
      $display("test decode done");
   end
   endtask

   // Every source active, only field n set to level 2
   task t_map;
   begin
      src(12'hFFF, 12'h000);
      for (i = 0; i < 12; i = i + 1)
      begin
         v = 24'hFFFFFF & ~(24'h1 << (2 * i));
         setv(v);
         cpu(1'b1, 2'h2, i[3:0]);
      end
      $display("test map done");
   end
   endtask

   task t_prio;
   begin
      setv(24'hF73FBF);
      cpu(1'b1, 2'h1, 4'h7);
      src(12'h000, 12'h080);
      cpu(1'b1, 2'h1, 4'h9);
      src(12'h000, 12'h200);
      cpu(1'b1, 2'h2, 4'h3);
      srcEna <= 12'hFF7;
      settle;
      cpu(1'b0, 2'h3, 4'h0);
      srcEna <= 12'hFFF;
      setv(24'hAAAAAA);
      cpu(1'b1, 2'h2, 4'h0);
      src(12'h000, 12'h001);
      cpu(1'b1, 2'h2, 4'h1);
      apb(1'b0, 12'h200, 32'h0);
      chk("tiests", rd & 32'h3, 32'h3);
      // Frozen controller must hold its winner while a line drops
      clkEn <= 1'b0;
      src(12'h000, 12'h002);
      cpu(1'b1, 2'h2, 4'h1);
      clkEn <= 1'b1;
      settle;
      cpu(1'b1, 2'h2, 4'h2);
      $display("test priority done");
   end
   endtask

   task t_regs;
   begin
      apb(1'b1, 12'h1FC, 32'h3);
      rdchk(12'h1FC, 32'h3);
      chk("testbits", testBits, 2'h3);
      apb(1'b0, 12'h300, 32'h0);
      chk("slverr", er, 1'b1);
      chk("errdata", rd, 32'h0);
      apb(1'b1, 12'h1FC, 32'h0);
      $display("test registers done");
   end
   endtask

   // A request set to none raises the masked event
   task t_irq;
   begin
      src(12'h000, 12'hFFF);
      setv(24'hFFFFFF);
      apb(1'b1, 12'h204, 32'h7);
      apb(1'b1, 12'h208, 32'h4);
      rdchk(12'h208, 32'h4);
      settle;
      chk("irq", irq, 1'b0);
      src(12'h001, 12'h000);
      chk("irq", irq, 1'b1);
      apb(1'b0, 12'h200, 32'h0);
      chk("status", rd & 32'h4, 32'h4);
      apb(1'b1, 12'h208, 32'h0);
      settle;
      chk("irq", irq, 1'b0);
      src(12'h000, 12'h001);
      apb(1'b1, 12'h204, 32'h4);
      apb(1'b1, 12'h208, 32'h4);
      settle;
      chk("irq", irq, 1'b0);
      $display("test interrupt done");
   end
   endtask

   initial
   begin
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      t_reset;
      t_decode;
      t_map;
      t_prio;
      t_regs;
      t_irq;
      end_of_test;
   end
endmodule // ilc_controller_tb_top
